// ### esrl_pkg.sv
package esrl_pkg;

  // Synchroniser reset image: {deep sleep ack (idle high), role select}
  localparam logic [1:0] SYNC_RST = 2'h2;
  localparam int SYNC_ROLE = 0;
  localparam int SYNC_ACK = 1;

  // Reset values of pins, and the value sent on the boot wires
  localparam logic WARN_RST = 1'h1;
  localparam logic SHARED_ACK_RST = 1'h0;
  localparam logic BOOT_WIRE_ONE = 1'h1;

  typedef enum logic [2:0] {
    ROLE_SECONDARY = 3'h1,
    ROLE_BOOT_SEND = 3'h2,
    ROLE_PRIMARY = 3'h4
  } esrl_role_e;

  // Upstream wire update offered to the link layer
  typedef struct packed {
    logic bootLoadDone;
    logic bootLoadStatus;
    logic susAckN;
    logic hostRstAck;
  } esrl_up_s;

endpackage : esrl_pkg

// ### esrl_sync.sv
`timescale 1ns/100ps
module esrl_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous inputs and filtered result
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] stable
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_stable;

  // A change only counts once the last two stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      next_stable[i] = (stage2[i] == stage3[i]) ? stage3[i] : stable[i];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
      stable <= RST_VAL;
    end else begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
      stable <= next_stable;
    end
  end

endmodule : esrl_sync

// ### esrl_role_logic.sv
// Notes on behaviour
// - Role input high primary, low secondary
// - Role input latched once high; a later fall is ignored
// - Primary: shared pin shows power-down ack wire
// - Primary: send both boot wires as one
// - Secondary: never send boot wires
// - Secondary: no handshake replies, wires informational
// - Secondary: ignore deep sleep ack pin
// - Secondary: shared pin shows host reset ack
// - Role low: withhold boot wires
// - Role rise: primary onward, send boot wires
// - Shared pin low first, then power-down ack
// - Wire exchange only after boot wires sent
// - Warn pin follows received warn wire always
// - Primary: each ack pin edge becomes wire
// - Secondary: reset ack rises after idle
`timescale 1ns/100ps
module esrl_role_logic (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Board pins
  input wire logic roleSelect,
  input wire logic deepSleepAckInN,
  output logic deepSleepWarnOutN,
  output logic sharedAckOut,
  // Received downstream wires
  input wire logic susWarnVwN,
  input wire logic susPwrDnAckVw,
  input wire logic hostRstWarnVw,
  // Bridge idle status
  input wire logic lpcIdle,
  input wire logic sirqIdle,
  // Upstream wire channel
  input wire logic upTaken,
  output logic upValid,
  output esrl_pkg::esrl_up_s upWires,
  // Role status
  output logic primaryRole,
  output logic vwExchangeEn
);

  logic [1:0] syncOut;
  logic roleSync;
  logic ackSync;

  esrl_sync #(
    .WIDTH(2),
    .RST_VAL(esrl_pkg::SYNC_RST)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .asyncIn({deepSleepAckInN, roleSelect}),
    .stable(syncOut)
  );

  assign roleSync = syncOut[esrl_pkg::SYNC_ROLE];
  assign ackSync = syncOut[esrl_pkg::SYNC_ACK];

  // Role state
  esrl_pkg::esrl_role_e role;
  esrl_pkg::esrl_role_e next_role;
  logic bootSent;
  logic next_bootSent;

  // Upstream handshake state
  logic ackPrev;
  logic next_ackPrev;
  logic ackPend;
  logic next_ackPend;
  logic hostWarnPrev;
  logic next_hostWarnPrev;
  logic hostRstAck;
  logic next_hostRstAck;
  logic resetAckPend;
  logic next_resetAckPend;
  logic hostAckPend;
  logic next_hostAckPend;
  esrl_pkg::esrl_up_s up;
  esrl_pkg::esrl_up_s next_up;

  // Pin drivers
  logic warnN;
  logic next_warnN;
  logic shared;
  logic next_shared;
  logic isPrimary;

  // Once primary, stays primary; a falling role input is not supported
  always_comb begin
    next_role = role;
    next_bootSent = bootSent;
    case (role)
      esrl_pkg::ROLE_SECONDARY: begin
        if (roleSync) begin
          next_role = esrl_pkg::ROLE_BOOT_SEND;
        end
      end
      esrl_pkg::ROLE_BOOT_SEND: begin
        // Hold the offer until the master gives a slot
        if (upValid && upTaken) begin
          next_role = esrl_pkg::ROLE_PRIMARY;
          next_bootSent = 1'h1;
        end
      end
      esrl_pkg::ROLE_PRIMARY: begin
        next_role = esrl_pkg::ROLE_PRIMARY;
      end
      default: begin
        next_role = esrl_pkg::ROLE_SECONDARY;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      role <= esrl_pkg::ROLE_SECONDARY;
      bootSent <= 1'h0;
    end else begin
      role <= next_role;
      bootSent <= next_bootSent;
    end
  end

  assign isPrimary = (role != esrl_pkg::ROLE_SECONDARY);

  // Pin edges and host reset handshake
  always_comb begin
    next_ackPrev = ackSync;
    next_ackPend = ackPend;
    next_hostWarnPrev = hostRstWarnVw;
    next_hostRstAck = hostRstAck;
    next_resetAckPend = resetAckPend;
    next_hostAckPend = hostAckPend;
    next_up = up;
    // Follow the next role so the very first offer carries the boot wires
    if (next_role != esrl_pkg::ROLE_SECONDARY) begin
      next_up.bootLoadDone = esrl_pkg::BOOT_WIRE_ONE;
      next_up.bootLoadStatus = esrl_pkg::BOOT_WIRE_ONE;
    end else begin
      next_up.bootLoadDone = 1'h0;
      next_up.bootLoadStatus = 1'h0;
    end
    if (upValid && upTaken) begin
      next_ackPend = 1'h0;
      next_hostAckPend = 1'h0;
    end
    // Edges in secondary role are dropped, not queued
    if (isPrimary && (ackSync != ackPrev)) begin
      next_up.susAckN = ackSync;
      next_ackPend = 1'h1;
    end
    // Hold off the acknowledge until the LPC side has drained
    if (hostRstWarnVw && !hostWarnPrev) begin
      next_resetAckPend = 1'h1;
    end
    if (!hostRstWarnVw) begin
      next_resetAckPend = 1'h0;
      if (hostRstAck) begin
        next_hostRstAck = 1'h0;
        next_up.hostRstAck = 1'h0;
        next_hostAckPend = isPrimary;
      end
    end else if (resetAckPend && lpcIdle && sirqIdle) begin
      next_resetAckPend = 1'h0;
      next_hostRstAck = 1'h1;
      next_up.hostRstAck = 1'h1;
      next_hostAckPend = isPrimary;
    end
  end

  // Pin drivers; the shared pin changes function with the role
  always_comb begin
    next_warnN = susWarnVwN;
    next_shared = isPrimary ? susPwrDnAckVw : hostRstAck;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      warnN <= esrl_pkg::WARN_RST;
      shared <= esrl_pkg::SHARED_ACK_RST;
    end else begin
      warnN <= next_warnN;
      shared <= next_shared;
    end
  end

  // Boot wires first, then handshake traffic; nothing in secondary role
  assign upValid = (role == esrl_pkg::ROLE_BOOT_SEND) ||
                   (bootSent && (ackPend || hostAckPend));
  assign upWires = up;
  assign deepSleepWarnOutN = warnN;
  assign sharedAckOut = shared;
  assign primaryRole = isPrimary;
  assign vwExchangeEn = bootSent;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ackPrev <= esrl_pkg::SYNC_RST[esrl_pkg::SYNC_ACK];
      ackPend <= 1'h0;
      hostWarnPrev <= 1'h0;
      hostRstAck <= 1'h0;
      resetAckPend <= 1'h0;
      hostAckPend <= 1'h0;
      up <= '{bootLoadDone: 1'h0, bootLoadStatus: 1'h0,
              susAckN: 1'h1, hostRstAck: 1'h0};
    end else begin
      ackPrev <= next_ackPrev;
      ackPend <= next_ackPend;
      hostWarnPrev <= next_hostWarnPrev;
      hostRstAck <= next_hostRstAck;
      resetAckPend <= next_resetAckPend;
      hostAckPend <= next_hostAckPend;
      up <= next_up;
    end
  end

endmodule : esrl_role_logic

// ### esrl_role_logic_props.sv
`timescale 1ns/100ps
module esrl_role_logic_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Board pins
  input wire logic roleSelect,
  input wire logic deepSleepAckInN,
  input wire logic deepSleepWarnOutN,
  input wire logic sharedAckOut,
  // Received wires and idle status
  input wire logic susWarnVwN,
  input wire logic susPwrDnAckVw,
  input wire logic hostRstWarnVw,
  input wire logic lpcIdle,
  input wire logic sirqIdle,
  // Upstream channel and role status
  input wire logic upTaken,
  input wire logic upValid,
  input wire esrl_pkg::esrl_up_s upWires,
  input wire logic primaryRole,
  input wire logic vwExchangeEn
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_warn_lag: assert property (!$past(rst) |->
    deepSleepWarnOutN == $past(susWarnVwN)) else $error("warn");
  a_sec_quiet: assert property (!primaryRole |-> !upValid)
    else $error("quiet");
  a_role_high: assert property (roleSelect [*8] |-> primaryRole)
    else $error("role");
  a_pd_ack: assert property ($past(primaryRole) |->
    sharedAckOut == $past(susPwrDnAckVw)) else $error("pd");
  a_boot_wires: assert property ($rose(primaryRole) |-> upValid &&
    upWires.bootLoadDone && upWires.bootLoadStatus) else $error("boot");
  a_exch_late: assert property ($rose(vwExchangeEn) |->
    primaryRole && $past(upValid && upTaken)) else $error("exch");
  a_ack_edge: assert property (vwExchangeEn && $fell(deepSleepAckInN)
    |-> ##[2:8] upValid && !upWires.susAckN) else $error("ack");
  a_host_ack: assert property (!primaryRole && $rose(sharedAckOut) |->
    $past(hostRstWarnVw, 2) && $past(lpcIdle && sirqIdle, 2))
    else $error("host");
  cover property ($rose(vwExchangeEn));
  cover property (!primaryRole && $rose(sharedAckOut));
  cover property (upTaken && !upWires.susAckN);
endmodule : esrl_role_logic_props
bind esrl_role_logic esrl_role_logic_props esrl_role_logic_props_inst (
  .clk(clk),
  .rst(rst),
  .roleSelect(roleSelect),
  .deepSleepAckInN(deepSleepAckInN),
  .deepSleepWarnOutN(deepSleepWarnOutN),
  .sharedAckOut(sharedAckOut),
  .susWarnVwN(susWarnVwN),
  .susPwrDnAckVw(susPwrDnAckVw),
  .hostRstWarnVw(hostRstWarnVw),
  .lpcIdle(lpcIdle),
  .sirqIdle(sirqIdle),
  .upTaken(upTaken),
  .upValid(upValid),
  .upWires(upWires),
  .primaryRole(primaryRole),
  .vwExchangeEn(vwExchangeEn)
);

// ### esrl_master_model.sv
`timescale 1ns/100ps
module esrl_master_model (
  // Upstream channel
  input wire logic clk, upValid,
  input wire esrl_pkg::esrl_up_s upWires,
  input wire logic [3:0] stall,
  output logic upTaken = 1'h0,
  output esrl_pkg::esrl_up_s got,
  output int takes = 0
);
  logic [3:0] waitCnt = 4'h0;
  // A busy master may stall before taking
  always @(negedge clk) begin
    waitCnt <= upTaken ? 4'h0 : waitCnt + {3'h0, upValid};
    upTaken <= !upTaken && upValid && waitCnt >= stall;
  end
  always @(posedge clk) begin
    if (upTaken) got <= upWires;
    if (upTaken) takes <= takes + 1;
  end
endmodule : esrl_master_model

// ### test_esrl_role_logic.sv
`timescale 1ns/100ps
module test_esrl_role_logic;
  logic clk = 1'h0, rst = 1'h1, roleSelect = 1'h0, linkClk = 1'h0;
  logic deepSleepAckInN = 1'h1, susWarnVwN = 1'h1, susPwrDnAckVw = 1'h0;
  logic hostRstWarnVw = 1'h0, lpcIdle = 1'h1, sirqIdle = 1'h1;
  logic deepSleepWarnOutN, sharedAckOut, upTaken, upValid;
  logic primaryRole, vwExchangeEn;
  logic [3:0] stall = 4'h0;
  esrl_pkg::esrl_up_s upWires, got;
  int takes, mismatches = 0, totalChecks = 0;
  esrl_role_logic esrl_role_logic_inst (
    .clk(clk),
    .rst(rst),
    .roleSelect(roleSelect),
    .deepSleepAckInN(deepSleepAckInN),
    .deepSleepWarnOutN(deepSleepWarnOutN),
    .sharedAckOut(sharedAckOut),
    .susWarnVwN(susWarnVwN),
    .susPwrDnAckVw(susPwrDnAckVw),
    .hostRstWarnVw(hostRstWarnVw),
    .lpcIdle(lpcIdle),
    .sirqIdle(sirqIdle),
    .upTaken(upTaken),
    .upValid(upValid),
    .upWires(upWires),
    .primaryRole(primaryRole),
    .vwExchangeEn(vwExchangeEn)
  );
  esrl_master_model esrl_master_model_inst (
    .clk(clk),
    .upValid(upValid),
    .upWires(upWires),
    .stall(stall),
    .upTaken(upTaken),
    .got(got),
    .takes(takes)
  );
  initial forever #5 clk = ~clk;
  initial #3 forever #80 linkClk = ~linkClk;
  // Outside logic echoes each warn edge, delayed to a link clock edge
  always @(posedge linkClk) begin
    @(negedge clk);
    deepSleepAckInN <= deepSleepWarnOutN;
  end
  task automatic chk(string n, logic s, logic e);
    totalChecks++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", n, e, s);
    end
  endtask : chk
  task automatic conclude();
    $display("%0d checks %0d mismatches", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic took(int n);
    for (int i = 0; i < 60 && takes < n; i++) tick(1);
    if (takes < n) $display("BAD takes expected %0d seen %0d", n, takes);
    mismatches += int'(takes < n);
    if (takes < n) conclude();
  endtask : took
  task automatic secondary();
    susWarnVwN = 1'h0;
    lpcIdle = 1'h0;
    hostRstWarnVw = 1'h1;
    tick(40);
    chk("warn", deepSleepWarnOutN, 1'h0);
    chk("secondary", primaryRole, 1'h0);
    chk("quiet", takes == 0, 1'h1);
    chk("held", sharedAckOut, 1'h0);
    lpcIdle = 1'h1;
    tick(4);
    chk("hostAck", sharedAckOut, 1'h1);
    susWarnVwN = 1'h1;
    hostRstWarnVw = 1'h0;
    tick(40);
    chk("low", sharedAckOut, 1'h0);
    $display("secondary ends");
  endtask : secondary
  task automatic delayedBoot();
    roleSelect = 1'h1;
    took(1);
    chk("boot", got.bootLoadDone && got.bootLoadStatus, 1'h1);
    tick(1);
    chk("primary", primaryRole && vwExchangeEn, 1'h1);
    chk("pdLow", sharedAckOut, 1'h0);
    susPwrDnAckVw = 1'h1;
    stall = 4'h2;
    susWarnVwN = 1'h0;
    took(2);
    chk("deep_sleep_ack_in", got.susAckN, 1'h0);
    chk("pd", sharedAckOut, 1'h1);
    $display("boot ends");
  endtask : delayedBoot
  task automatic primaryReset();
    susPwrDnAckVw = 1'h0;
    hostRstWarnVw = 1'h1;
    took(3);
    chk("hostVw", got.hostRstAck, 1'h1);
    chk("pdPin", sharedAckOut, 1'h0);
    chk("warnP", deepSleepWarnOutN, 1'h0);
    hostRstWarnVw = 1'h0;
    took(4);
    chk("hostVwLow", got.hostRstAck, 1'h0);
    $display("primary reset ends");
  endtask : primaryReset
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 1'h0;
    secondary();
    delayedBoot();
    primaryReset();
    conclude();
  end
endmodule : test_esrl_role_logic
